/* File: hocd_pkg.sv */
// Constants and types of the hall output conditioning datapath
package hocd_pkg;
  localparam int SAMPLE_W   = 14;
  localparam int GAIN_W     = 14;
  localparam int GAIN_FRAC  = 11;
  localparam int OFFSET_W   = 11;
  localparam int CLAMP_W    = 11;
  localparam int DAC_W      = 12;
  localparam int ACC_W      = 30;
  localparam int REG_W      = 16;
  localparam int ADDR_W     = 3;

  localparam logic [ADDR_W-1:0] ADDR_GAIN   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CLAMPL = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CLAMPH = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_LOCK   = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_RAW    = 3'h5;

  localparam logic [GAIN_W-1:0]   GAIN_RST   = 14'h0800;
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 11'h200;
  localparam logic [CLAMP_W-1:0]  CLAMPL_RST = 11'h000;
  localparam logic [CLAMP_W-1:0]  CLAMPH_RST = 11'h7FF;
  localparam logic [DAC_W-1:0]    DAC_MAX    = 12'hFFF;
endpackage : hocd_pkg

/* File: hocd_top.sv */
// Gain, offset and clamp datapath with calibration register file and lock
//
// Function
// - Signed gain -4..+4 multiplies sample, 11 fraction bits, step 1/2048.
// - Gain one: 2048 sample counts move output by full supply span.
// - Output derives from converter sample; same sample readable as register.
// - Offset added after multiply; offset spans minus to plus supply.
// - Negative offset caps output at offset plus full supply unless lower limit lies above that.
// - Output held at or above lower limit, zero to half supply.
// - Output held at or below upper limit, zero to full supply, unless lower limit lies above it.
// - Lock freezes all registers and ignores every read and write request.
// - Lock bit, once set, clears only on reset.
// - Raw sample register is 14 bits, read-only, before gain stage.
// - Unlocked settings may be rewritten any number of times.
// - Write-and-store commits values into nonvolatile store.
// - Order is multiply, add offset, then upper and lower limit.
`timescale 1ns/10ps
module hocd_top (
  input  wire logic                           i_clk,       // 25 MHz clock
  input  wire logic                           i_rst,       // Async reset, high
  input  wire logic signed [hocd_pkg::SAMPLE_W-1:0] i_sample, // Filtered converter value
  input  wire logic                           i_req,       // Decoded telegram strobe
  input  wire logic                           i_wr,        // 1 write-and-store, 0 read
  input  wire logic [hocd_pkg::ADDR_W-1:0]    i_addr,      // Register select
  input  wire logic [hocd_pkg::REG_W-1:0]     i_wdata,     // Write value
  output logic                                o_ack,       // Request answered
  output logic [hocd_pkg::REG_W-1:0]          o_rdata,     // Read value
  output logic                                o_nv_store,  // Commit pulse to nonvolatile store
  output logic                                o_locked,    // Lock state
  output logic [hocd_pkg::DAC_W-1:0]          o_dac        // Code to output converter
);
  import hocd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [GAIN_W-1:0]   gain_q,   gain_d;
  logic [OFFSET_W-1:0] offset_q, offset_d;
  logic [CLAMP_W-1:0]  clampl_q, clampl_d, clamph_q, clamph_d;
  logic                lock_q,   lock_d;
  logic                ack_q,    ack_d;
  logic                store_q,  store_d;
  logic [REG_W-1:0]    rdata_q,  rdata_d;
  logic                take;

  assign take = i_req & ~lock_q;

  always_comb begin
    gain_d   = gain_q;
    offset_d = offset_q;
    clampl_d = clampl_q;
    clamph_d = clamph_q;
    lock_d   = lock_q;
    ack_d    = take;
    store_d  = 1'b0;
    rdata_d  = rdata_q;
    if (take && i_wr) begin
      store_d = 1'b1;
      unique case (i_addr)
        ADDR_GAIN:   gain_d   = i_wdata[GAIN_W-1:0];
        ADDR_OFFSET: offset_d = i_wdata[OFFSET_W-1:0];
        ADDR_CLAMPL: clampl_d = {1'b0, i_wdata[CLAMP_W-2:0]};
        ADDR_CLAMPH: clamph_d = i_wdata[CLAMP_W-1:0];
        ADDR_LOCK:   lock_d   = lock_q | i_wdata[0];
        default:     store_d  = 1'b0;
      endcase
    end else if (take) begin
      unique case (i_addr)
        ADDR_GAIN:   rdata_d = {{(REG_W-GAIN_W){1'b0}}, gain_q};
        ADDR_OFFSET: rdata_d = {{(REG_W-OFFSET_W){1'b0}}, offset_q};
        ADDR_CLAMPL: rdata_d = {{(REG_W-CLAMP_W){1'b0}}, clampl_q};
        ADDR_CLAMPH: rdata_d = {{(REG_W-CLAMP_W){1'b0}}, clamph_q};
        ADDR_LOCK:   rdata_d = {{(REG_W-1){1'b0}}, lock_q};
        ADDR_RAW:    rdata_d = {{(REG_W-SAMPLE_W){1'b0}}, i_sample};
        default:     rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_q   <= GAIN_RST;
      offset_q <= OFFSET_RST;
      clampl_q <= CLAMPL_RST;
      clamph_q <= CLAMPH_RST;
      lock_q   <= 1'b0;
      ack_q    <= 1'b0;
      store_q  <= 1'b0;
      rdata_q  <= '0;
    end else begin
      gain_q   <= gain_d;
      offset_q <= offset_d;
      clampl_q <= clampl_d;
      clamph_q <= clamph_d;
      lock_q   <= lock_d;
      ack_q    <= ack_d;
      store_q  <= store_d;
      rdata_q  <= rdata_d;
    end
  end

  assign o_ack      = ack_q;
  assign o_rdata    = rdata_q;
  assign o_nv_store = store_q;
  assign o_locked   = lock_q;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath: output code = sample*gain/2048 * 4096/2048 + offset*4
  logic signed [ACC_W-1:0] prod, sum, lo, hi, off4;
  logic [DAC_W-1:0]        dac_d, dac_q;

  always_comb begin
    // multiply, 4096 codes per 2048 counts at gain one
    prod = ACC_W'($signed(i_sample) * $signed(gain_q)) >>> (GAIN_FRAC - 1);
    // offset LSB four output codes, sign kept
    off4 = ACC_W'($signed({offset_q, 2'b00}));
    sum  = prod + off4;
    // upper limit LSB two output codes
    hi   = ACC_W'({1'b0, clamph_q, 1'b0});
    // negative offset caps at offset plus full span
    if (off4 + $signed(ACC_W'(DAC_MAX)) < hi)
      hi = off4 + $signed(ACC_W'(DAC_MAX));
    // lower limit LSB two codes, half-supply range
    lo   = ACC_W'({clampl_q[CLAMP_W-2:0], 1'b0});
    if (hi > $signed(ACC_W'(DAC_MAX)))
      hi = $signed(ACC_W'(DAC_MAX));
    if (sum > hi)
      sum = hi;
    if (sum < lo)
      sum = lo;
    if (sum < 0)
      sum = '0;
    dac_d = sum[DAC_W-1:0];
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) dac_q <= '0;
    else       dac_q <= dac_d;
  end

  assign o_dac = dac_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_lock_sticky;
    @(posedge i_clk) disable iff (i_rst) lock_q |=> lock_q;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

  property p_locked_silent;
    @(posedge i_clk) disable iff (i_rst) lock_q |=> !o_ack && !o_nv_store;
  endproperty
  a_locked_silent: assert property (p_locked_silent) else $error("answer while locked");

  property p_locked_frozen;
    @(posedge i_clk) disable iff (i_rst) lock_q |=> $stable(gain_q) && $stable(offset_q)
      && $stable(clampl_q) && $stable(clamph_q);
  endproperty
  a_locked_frozen: assert property (p_locked_frozen) else $error("register changed when locked");

  property p_rewrite;
    @(posedge i_clk) disable iff (i_rst) (i_req && i_wr && !lock_q && i_addr == ADDR_GAIN)
      |=> gain_q == $past(i_wdata[GAIN_W-1:0]) && o_nv_store;
  endproperty
  a_rewrite: assert property (p_rewrite) else $error("gain write lost");

  property p_raw_read;
    @(posedge i_clk) disable iff (i_rst) (i_req && !i_wr && !lock_q && i_addr == ADDR_RAW)
      |=> o_ack && o_rdata[SAMPLE_W-1:0] == $past(i_sample);
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw readout wrong");

  property p_upper;
    @(posedge i_clk) disable iff (i_rst) 1'b1 |=> ACC_W'(o_dac) <= ACC_W'({1'b0, $past(clamph_q), 1'b0});
  endproperty
  a_upper: assert property (p_upper) else $error("above upper limit");

  property p_lower;
    @(posedge i_clk) disable iff (i_rst)
      1'b1 |=> ACC_W'(o_dac) >= ACC_W'({$past(clampl_q[CLAMP_W-2:0]), 1'b0});
  endproperty
  a_lower: assert property (p_lower) else $error("below lower limit");

  property p_zero_offset;
    @(posedge i_clk) disable iff (i_rst)
      (i_sample == '0 && !offset_q[OFFSET_W-1] && {offset_q, 1'b0} >= {2'b00, clampl_q[CLAMP_W-2:0]}
       && {offset_q, 1'b0} <= {1'b0, clamph_q}) |=> ACC_W'(o_dac) == ACC_W'({$past(offset_q), 2'b00});
  endproperty
  a_zero_offset: assert property (p_zero_offset) else $error("zero sample not at offset");

  property p_neg_cap;
    @(posedge i_clk) disable iff (i_rst) (offset_q[OFFSET_W-1] && clampl_q[CLAMP_W-2:0] == '0)
      |=> $signed({1'b0, o_dac}) <= $signed({$past(offset_q), 2'b00}) + $signed({1'b0, DAC_MAX});
  endproperty
  a_neg_cap: assert property (p_neg_cap) else $error("above offset plus supply");

  property p_store;
    @(posedge i_clk) disable iff (i_rst) (i_req && i_wr && !lock_q && i_addr <= ADDR_LOCK)
      |=> o_ack && o_nv_store;
  endproperty
  a_store: assert property (p_store) else $error("write not committed");

  property p_no_store;
    @(posedge i_clk) disable iff (i_rst) (i_req && i_wr && !lock_q && i_addr >= ADDR_RAW)
      |=> o_ack && !o_nv_store;
  endproperty
  a_no_store: assert property (p_no_store) else $error("store on read-only address");

  property p_lock_set;
    @(posedge i_clk) disable iff (i_rst) (i_req && i_wr && !lock_q && i_addr == ADDR_LOCK && i_wdata[0])
      |=> o_locked;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");

  c_lock: cover property (@(posedge i_clk) disable iff (i_rst) $rose(lock_q));
  c_floor: cover property (@(posedge i_clk) disable iff (i_rst) o_dac == '0);
  c_store: cover property (@(posedge i_clk) disable iff (i_rst) o_nv_store);
  c_clip_hi: cover property (@(posedge i_clk) disable iff (i_rst) o_dac == {clamph_q, 1'b0});
endmodule : hocd_top

/* File: hocd_prog_model.sv */
// Programmer model issuing read and write-and-store requests
`timescale 1ns/10ps
module hocd_prog_model (
  input  wire logic                       i_clk,   // Device clock
  input  wire logic                       i_ack,   // Request answered
  input  wire logic [hocd_pkg::REG_W-1:0] i_rdata, // Read value
  output logic                            o_req,   // Request strobe
  output logic                            o_wr,    // Write-and-store select
  output logic [hocd_pkg::ADDR_W-1:0]     o_addr,  // Register select
  output logic [hocd_pkg::REG_W-1:0]      o_wdata  // Write value
);
  import hocd_pkg::*;
  initial begin
    o_req   = 1'b0;
    o_wr    = 1'b0;
    o_addr  = 3'h0;
    o_wdata = 16'h0000;
  end
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
                      output logic ack, output logic [REG_W-1:0] rd);
    @(negedge i_clk);
    o_req   = 1'b1;
    o_wr    = wr;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_clk);
    ack     = i_ack;
    rd      = i_rdata;
    o_req   = 1'b0;
    o_wdata = ~d;
  endtask : xfer
endmodule : hocd_prog_model

/* File: hocd_top_tb.sv */
// Self-checking testbench of the conditioning datapath
`timescale 1ns/10ps
module hocd_top_tb;
  import hocd_pkg::*;
  logic                       i_clk = 1'b0;
  logic                       i_rst = 1'b1;
  logic signed [SAMPLE_W-1:0] i_sample = '0;
  logic                       req, wr, ack, nv, locked, got;
  logic [ADDR_W-1:0]          addr;
  logic [REG_W-1:0]           wdata, rdata, rd;
  logic [DAC_W-1:0]           dac;
  int                         n_mismatch = 0;
  int                         n_compared = 0;
  always #20 i_clk = ~i_clk;
  hocd_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_sample(i_sample), .i_req(req), .i_wr(wr), .i_addr(addr),
    .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata), .o_nv_store(nv), .o_locked(locked), .o_dac(dac));
  hocd_prog_model prog (.i_clk(i_clk), .i_ack(ack), .i_rdata(rdata), .o_req(req), .o_wr(wr), .o_addr(addr),
    .o_wdata(wdata));
  task automatic chk(input logic [REG_W-1:0] g, input logic [REG_W-1:0] e, input string what);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : chk
  function automatic logic [DAC_W-1:0] exp_dac(int s, int g, int off, int lo, int hi);
    int v;
    int top;
    v = ((s * g) >>> 10) + 4 * off;
    top = 2 * hi;
    if (4 * off + 4095 < top) top = 4 * off + 4095;
    if (top > 4095) top = 4095;
    if (v > top) v = top;
    if (v < 2 * lo) v = 2 * lo;
    if (v < 0) v = 0;
    return v[DAC_W-1:0];
  endfunction : exp_dac
  task automatic put(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d, input logic e);
    prog.xfer(1'b1, a, d, got, rd);
    chk({15'h0000, got}, {15'h0000, e}, "write ack");
    chk({15'h0000, nv}, {15'h0000, e && (a < 3'h5)}, "store pulse");
  endtask : put
  task automatic get(input logic [ADDR_W-1:0] a, input logic e, input logic [REG_W-1:0] d);
    prog.xfer(1'b0, a, 16'h0000, got, rd);
    chk({15'h0000, got}, {15'h0000, e}, "read ack");
    if (e) chk(rd, d, "read data");
  endtask : get
  task automatic dacchk(input int s, input int g, input int off, input int lo, input int hi);
    @(negedge i_clk);
    i_sample = s[SAMPLE_W-1:0];
    repeat (2) @(negedge i_clk);
    chk({4'h0, dac}, {4'h0, exp_dac(s, g, off, lo, hi)}, "output code");
  endtask : dacchk
  task automatic test_done;
    $display("TB: compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(negedge i_clk);
    i_rst = 1'b0;
    dacchk(100, 2048, 512, 0, 2047);
    get(ADDR_RAW, 1'b1, 16'h0064);
    dacchk(-5, 2048, 512, 0, 2047);
    put(ADDR_RAW, 16'h1234, 1'b1);
    get(ADDR_RAW, 1'b1, 16'h3FFB);
    put(ADDR_GAIN, 16'h3800, 1'b1);
    dacchk(2000, -2048, 512, 0, 2047);
    put(ADDR_OFFSET, 16'h0700, 1'b1);
    put(ADDR_GAIN, 16'h0800, 1'b1);
    dacchk(3000, 2048, -256, 0, 2047);
    put(ADDR_GAIN, 16'h1FFF, 1'b1);
    put(ADDR_OFFSET, 16'h0000, 1'b1);
    dacchk(200, 8191, 0, 0, 2047);
    $display("TB: datapath test done");
    put(ADDR_CLAMPL, 16'h05F4, 1'b1);
    get(ADDR_CLAMPL, 1'b1, 16'h01F4);
    put(ADDR_CLAMPH, 16'h03E8, 1'b1);
    get(ADDR_CLAMPH, 1'b1, 16'h03E8);
    dacchk(0, 8191, 0, 500, 1000);
    dacchk(300, 8191, 0, 500, 1000);
    get(3'h6, 1'b1, 16'h0000);
    put(3'h7, 16'hFFFF, 1'b1);
    $display("TB: register test done");
    put(ADDR_CLAMPL, 16'h00CD, 1'b1);
    put(ADDR_CLAMPH, 16'h0733, 1'b1);
    dacchk(-2500, 8191, 0, 205, 1843);
    get(ADDR_RAW, 1'b1, 16'h363C);
    dacchk(2350, 8191, 0, 205, 1843);
    get(ADDR_RAW, 1'b1, 16'h092E);
    put(ADDR_GAIN, 16'h3D4C, 1'b1);
    put(ADDR_OFFSET, 16'h01F3, 1'b1);
    get(ADDR_GAIN, 1'b1, 16'h3D4C);
    get(ADDR_OFFSET, 1'b1, 16'h01F3);
    dacchk(-2500, -692, 499, 205, 1843);
    dacchk(2350, -692, 499, 205, 1843);
    $display("TB: calibration test done");
    put(ADDR_LOCK, 16'h0000, 1'b1);
    get(ADDR_LOCK, 1'b1, 16'h0000);
    chk({15'h0000, locked}, 16'h0000, "lock level");
    put(ADDR_LOCK, 16'h0001, 1'b1);
    chk({15'h0000, locked}, 16'h0001, "lock level");
    put(ADDR_CLAMPH, 16'h07FF, 1'b0);
    get(ADDR_RAW, 1'b0, 16'h0000);
    dacchk(300, -692, 499, 205, 1843);
    put(ADDR_LOCK, 16'h0000, 1'b0);
    chk({15'h0000, locked}, 16'h0001, "lock level");
    $display("TB: lock test done");
    test_done();
  end
  initial begin
    #(40 * 5000);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule : hocd_top_tb
